/* File: rtl/esq_pkg.sv */
// constants and types shared by the storage sequence controller files
package esq_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [15:0] ESQ_SEQ_BASE = 16'h0E5E;
  localparam logic [15:0] ESQ_SEQ_LAST = 16'h0E6F;
  localparam logic [15:0] ESQ_UPD_OFS = 16'h0E5E;
  localparam logic [15:0] ESQ_CAL_OFS = 16'h0E5F;
  localparam logic [15:0] ESQ_SYNC_OFS = 16'h0E60;
  localparam logic [15:0] ESQ_TERM_OFS = 16'h0E61;
  localparam logic [15:0] ESQ_SPARE_OFS = 16'h0E62;
  localparam logic [15:0] ESQ_CTRL_OFS = 16'h0E80;
  localparam logic [15:0] ESQ_STAT_OFS = 16'h0E81;
  localparam logic [15:0] ESQ_PTRH_OFS = 16'h0E82;
  localparam logic [15:0] ESQ_PTRL_OFS = 16'h0E83;
  localparam logic [15:0] ESQ_KEY_OFS = 16'h0FFF;
  localparam logic [15:0] ESQ_CALREF0_OFS = 16'h1488;
  localparam logic [15:0] ESQ_CALREF_STEP = 16'h0100;

  // ************************************************************
  // sizes, reset values and field positions
  // ************************************************************
  localparam int ESQ_SEQ_DEPTH = 32'h12;
  localparam int ESQ_IDX_W = 32'h5;
  localparam int ESQ_LOOPS = 32'h4;
  localparam int ESQ_PUSH_W = 32'h18;
  localparam logic [7:0] ESQ_UPD_RST = 8'h80;
  localparam logic [7:0] ESQ_CAL_RST = 8'h92;
  localparam logic [7:0] ESQ_SYNC_RST = 8'hA0;
  localparam logic [7:0] ESQ_TERM_RST = 8'hFF;
  localparam logic [7:0] ESQ_SPARE_RST = 8'h00;
  localparam logic [7:0] ESQ_KEY_RST = 8'h00;
  localparam logic [2:0] ESQ_CALREF_RST = 3'h0;
  localparam int ESQ_LVL_LSB = 32'h1;
  localparam int ESQ_MEN_BIT = 32'h0;
  localparam int ESQ_START_BIT = 32'h0;

  // ************************************************************
  // sequence opcodes and key
  // ************************************************************
  localparam logic [7:0] ESQ_OP_UPDATE = 8'h80;
  localparam logic [7:0] ESQ_OP_CAL = 8'h92;
  localparam logic [7:0] ESQ_OP_SYNC = 8'hA0;
  localparam logic [7:0] ESQ_OP_END = 8'hFF;
  localparam logic [7:0] ESQ_OP_PAUSE = 8'hFE;
  localparam logic [7:0] ESQ_DATA_MAX = 8'h7F;
  localparam logic [7:0] ESQ_KEY_OPEN = 8'hF9;
  localparam logic [31:0] ESQ_CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] ESQ_CRC_INIT = 32'hFFFFFFFF;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_OP, ST_AHI, ST_ALO, ST_COPY, ST_CRC
  } esq_state_t;

endpackage

/* File: rtl/esq_strm_if.sv */
// valid/ready byte stream carrying eeprom address and data
`timescale 1ns/10ps
interface esq_strm_if;
  logic valid;
  logic ready;
  logic [23:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* File: rtl/esq_seq_mem.sv */
// storage sequence entry memory with two registered read ports
`timescale 1ns/10ps
module esq_seq_mem import esq_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic [ESQ_IDX_W-1:0] i_widx,
  input wire logic [7:0] i_wdata,
  input wire logic i_ra_en,
  input wire logic i_ra_sel,
  input wire logic [ESQ_IDX_W-1:0] i_ra_idx,
  input wire logic [7:0] i_ra_alt,
  output logic [7:0] o_ra_data,
  input wire logic i_rb_sel,
  input wire logic [ESQ_IDX_W-1:0] i_rb_idx,
  input wire logic [7:0] i_rb_alt,
  output logic [7:0] o_rb_data
);
  logic [7:0] mem_q [ESQ_SEQ_DEPTH];

  function automatic logic [7:0] entry_rst(input int idx);
    case (idx)
      0: return ESQ_UPD_RST;
      1: return ESQ_CAL_RST;
      2: return ESQ_SYNC_RST;
      3: return ESQ_TERM_RST;
      default: return ESQ_SPARE_RST;
    endcase
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      for (int k = 0; k < ESQ_SEQ_DEPTH; k++) begin
        mem_q[k] <= entry_rst(k);
      end
    end else if (i_wr) begin
      mem_q[i_widx] <= i_wdata;
    end
  end

  // port a serves the bus, other registers pass through the alt input
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_ra_data <= 8'h00;
    end else if (!i_ra_en) begin
      o_ra_data <= 8'h00;
    end else begin
      o_ra_data <= i_ra_sel ? mem_q[i_ra_idx] : i_ra_alt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rb_data <= 8'h00;
    end else begin
      o_rb_data <= i_rb_sel ? mem_q[i_rb_idx] : i_rb_alt;
    end
  end
endmodule

/* File: rtl/esq_skid_buf.sv */
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/10ps
module esq_skid_buf (
  input wire logic i_clock,
  input wire logic i_nrst,
  esq_strm_if.snk i_in,
  esq_strm_if.src o_out
);
  logic out_valid_q;
  logic [23:0] out_data_q;
  logic skid_valid_q;
  logic [23:0] skid_data_q;
  logic take_in;
  logic drain;

  assign i_in.ready = !skid_valid_q;
  assign take_in = i_in.valid && !skid_valid_q;
  assign drain = !out_valid_q || o_out.ready;
  assign o_out.valid = out_valid_q;
  assign o_out.data = out_data_q;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      out_valid_q <= 1'b0;
      out_data_q <= 24'h000000;
      skid_valid_q <= 1'b0;
      skid_data_q <= 24'h000000;
    end else if (drain) begin
      if (skid_valid_q) begin
        out_valid_q <= 1'b1;
        out_data_q <= skid_data_q;
        skid_valid_q <= 1'b0;
      end else begin
        out_valid_q <= take_in;
        if (take_in) begin
          out_data_q <= i_in.data;
        end
      end
    end else if (take_in) begin
      skid_valid_q <= 1'b1;
      skid_data_q <= i_in.data;
    end
  end
endmodule

/* File: rtl/esq_store_ctl.sv */
// storage sequence walker, calibration reference key and registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module esq_store_ctl import esq_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_ee_valid,
  output logic [15:0] o_ee_addr,
  output logic [7:0] o_ee_data,
  input wire logic i_ee_ready,
  output logic o_busy,
  output logic o_ref_open,
  output logic [7:0] o_cal_level,
  output logic [3:0] o_man_en
);

  // ************************************************************
  // declarations
  // ************************************************************
  esq_state_t state_q;
  esq_state_t ret_q;
  logic [15:0] seq_ptr_q;
  logic [15:0] rd_addr_q;
  logic [15:0] src_q;
  logic [6:0] cnt_q;
  logic [1:0] crc_i_q;
  logic pause_q;
  logic busy_q;
  logic err_q;
  logic [15:0] ee_ptr_q;
  logic [31:0] crc_q;
  logic [31:0] crc_out;
  logic [7:0] key_q;
  logic ref_open_q;
  logic [2:0] calref_q [ESQ_LOOPS];
  logic [2:0] cr_dec;
  logic [7:0] rb_data;
  logic [7:0] push_byte;
  logic push_go;
  logic start;

  esq_strm_if push_if ();
  esq_strm_if out_if ();

  // ************************************************************
  // helper functions
  // ************************************************************
  function automatic logic seq_hit(input logic [15:0] a);
    return (a >= ESQ_SEQ_BASE) && (a <= ESQ_SEQ_LAST);
  endfunction

  function automatic logic [ESQ_IDX_W-1:0] seq_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - ESQ_SEQ_BASE;
    return d[ESQ_IDX_W-1:0];
  endfunction

  function automatic logic [2:0] calref_dec(input logic [15:0] a);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < ESQ_LOOPS; k++) begin
      if (a == ESQ_CALREF0_OFS + 16'(k) * ESQ_CALREF_STEP) begin
        r = {1'b1, 2'(k)};
      end
    end
    return r;
  endfunction

  // value of every register outside the sequence area
  function automatic logic [7:0] map_read(input logic [15:0] a);
    logic [2:0] c;
    c = calref_dec(a);
    if (c[2]) begin
      return {5'h00, calref_q[c[1:0]]};
    end
    case (a)
      ESQ_KEY_OFS: return key_q;
      ESQ_STAT_OFS: return {6'h00, err_q, busy_q};
      ESQ_PTRH_OFS: return ee_ptr_q[15:8];
      ESQ_PTRL_OFS: return ee_ptr_q[7:0];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ ESQ_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ************************************************************
  // access key and calibration references
  // ************************************************************
  assign cr_dec = calref_dec(i_addr);

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      key_q <= ESQ_KEY_RST;
      ref_open_q <= 1'b0;
    end else if (i_wr && i_addr == ESQ_KEY_OFS) begin
      key_q <= i_wdata;
      ref_open_q <= (i_wdata == ESQ_KEY_OPEN);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      for (int k = 0; k < ESQ_LOOPS; k++) begin
        calref_q[k] <= ESQ_CALREF_RST;
      end
    end else if (i_wr && cr_dec[2] && ref_open_q) begin
      calref_q[cr_dec[1:0]] <= i_wdata[2:0];
    end
  end

  always_comb begin
    for (int k = 0; k < ESQ_LOOPS; k++) begin
      o_cal_level[2*k +: 2] = calref_q[k][ESQ_LVL_LSB +: 2];
      o_man_en[k] = calref_q[k][ESQ_MEN_BIT];
    end
  end

  assign o_ref_open = ref_open_q;
  assign o_busy = busy_q;

  // ************************************************************
  // sequence memory and register read path
  // ************************************************************
  esq_seq_mem u_mem (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_wr(i_wr && seq_hit(i_addr)),
    .i_widx(seq_idx(i_addr)),
    .i_wdata(i_wdata),
    .i_ra_en(i_rd),
    .i_ra_sel(seq_hit(i_addr)),
    .i_ra_idx(seq_idx(i_addr)),
    .i_ra_alt(map_read(i_addr)),
    .o_ra_data(o_rdata),
    .i_rb_sel(seq_hit(rd_addr_q)),
    .i_rb_idx(seq_idx(rd_addr_q)),
    .i_rb_alt(map_read(rd_addr_q)),
    .o_rb_data(rb_data)
  );

  // ************************************************************
  // eeprom byte stream
  // ************************************************************
  assign crc_out = ~crc_q;
  assign push_byte = (state_q == ST_CRC) ? crc_out[8*crc_i_q +: 8] : rb_data;
  assign push_if.valid = (state_q == ST_OP) || (state_q == ST_AHI) || (state_q == ST_ALO)
    || (state_q == ST_COPY) || (state_q == ST_CRC);
  assign push_if.data = {ee_ptr_q, push_byte};
  assign push_go = push_if.valid && push_if.ready;

  esq_skid_buf u_buf (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_in(push_if),
    .o_out(out_if)
  );

  assign out_if.ready = i_ee_ready;
  assign o_ee_valid = out_if.valid;
  assign o_ee_addr = out_if.data[23:8];
  assign o_ee_data = out_if.data[7:0];

  assign start = i_wr && i_addr == ESQ_CTRL_OFS && i_wdata[ESQ_START_BIT] && state_q == ST_IDLE;

  // eeprom address pointer: one step per stored byte, back to zero after the last checksum byte of an end entry
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ee_ptr_q <= 16'h0000;
    end else if (push_go) begin
      if (state_q == ST_CRC && crc_i_q == 2'h3 && !pause_q) begin
        ee_ptr_q <= 16'h0000;
      end else begin
        ee_ptr_q <= ee_ptr_q + 16'h0001;
      end
    end
  end

  // crc runs over every byte stored before the checksum itself
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      crc_q <= ESQ_CRC_INIT;
    end else if (start) begin
      crc_q <= ESQ_CRC_INIT;
    end else if (push_go && state_q != ST_CRC) begin
      crc_q <= crc_step(crc_q, push_byte);
    end
  end

  // ************************************************************
  // sequence walker
  // ************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      seq_ptr_q <= ESQ_SEQ_BASE;
      rd_addr_q <= ESQ_SEQ_BASE;
      src_q <= 16'h0000;
      cnt_q <= 7'h00;
      crc_i_q <= 2'h0;
      pause_q <= 1'b0;
      busy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_READ;
            ret_q <= ST_OP;
            seq_ptr_q <= ESQ_SEQ_BASE;
            rd_addr_q <= ESQ_SEQ_BASE;
            busy_q <= 1'b1;
            err_q <= 1'b0;
          end
        end
        ST_READ: begin
          // running off the area means no terminator was programmed
          if (rd_addr_q > ESQ_SEQ_LAST && ret_q != ST_COPY) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            err_q <= 1'b1;
          end else begin
            state_q <= ret_q;
          end
        end
        ST_OP: begin
          if (push_go) begin
            if (rb_data == ESQ_OP_END || rb_data == ESQ_OP_PAUSE) begin
              state_q <= ST_CRC;
              crc_i_q <= 2'h0;
              pause_q <= (rb_data == ESQ_OP_PAUSE);
            end else begin
              seq_ptr_q <= seq_ptr_q + 16'h0001;
              rd_addr_q <= seq_ptr_q + 16'h0001;
              state_q <= ST_READ;
              ret_q <= (rb_data <= ESQ_DATA_MAX) ? ST_AHI : ST_OP;
              cnt_q <= rb_data[6:0];
            end
          end
        end
        ST_AHI: begin
          if (push_go) begin
            src_q[15:8] <= rb_data;
            seq_ptr_q <= seq_ptr_q + 16'h0001;
            rd_addr_q <= seq_ptr_q + 16'h0001;
            state_q <= ST_READ;
            ret_q <= ST_ALO;
          end
        end
        ST_ALO: begin
          if (push_go) begin
            src_q[7:0] <= rb_data;
            seq_ptr_q <= seq_ptr_q + 16'h0001;
            rd_addr_q <= {src_q[15:8], rb_data};
            state_q <= ST_READ;
            ret_q <= ST_COPY;
          end
        end
        ST_COPY: begin
          if (push_go) begin
            state_q <= ST_READ;
            if (cnt_q == 7'h00) begin
              rd_addr_q <= seq_ptr_q;
              ret_q <= ST_OP;
            end else begin
              cnt_q <= cnt_q - 7'h01;
              src_q <= src_q + 16'h0001;
              rd_addr_q <= src_q + 16'h0001;
              ret_q <= ST_COPY;
            end
          end
        end
        ST_CRC: begin
          if (push_go) begin
            if (crc_i_q == 2'h3) begin
              state_q <= ST_IDLE;
              busy_q <= 1'b0;
            end else begin
              crc_i_q <= crc_i_q + 2'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_op_push(logic [7:0] v);
    state_q == ST_OP && push_go && rb_data == v;
  endsequence

  sequence s_last_crc;
    state_q == ST_CRC && push_go && crc_i_q == 2'h3;
  endsequence

  sequence s_spare_wr_rd;
    (i_wr && i_addr == ESQ_SPARE_OFS) ##1 (i_rd && i_addr == ESQ_SPARE_OFS);
  endsequence

  AST_UPD_STORE: assert property (s_op_push(ESQ_OP_UPDATE) |->
    (push_if.data[7:0] == 8'h80) ##1 (ee_ptr_q == $past(ee_ptr_q) + 16'h0001))
    else $error("update entry not stored with pointer step");

  AST_CAL_STORE: assert property (s_op_push(ESQ_OP_CAL) |->
    (push_if.data[7:0] == 8'h92) ##1 (ee_ptr_q == $past(ee_ptr_q) + 16'h0001))
    else $error("calibrate entry not stored with pointer step");

  AST_SYNC_STORE: assert property (s_op_push(ESQ_OP_SYNC) |->
    (push_if.data[7:0] == 8'hA0) ##1 (ee_ptr_q == $past(ee_ptr_q) + 16'h0001))
    else $error("sync entry not stored with pointer step");

  AST_END_CRC: assert property (s_op_push(ESQ_OP_END) |=>
    state_q == ST_CRC && crc_i_q == 2'h0 && !pause_q)
    else $error("end entry not followed by checksum bytes");

  AST_END_RESET: assert property ((s_last_crc ##0 !pause_q) |=>
    ee_ptr_q == 16'h0000 && state_q == ST_IDLE && !busy_q)
    else $error("end did not reset pointer and go idle");

  AST_PAUSE_ADV: assert property ((s_last_crc ##0 pause_q) |=>
    ee_ptr_q == $past(ee_ptr_q) + 16'h0001 && state_q == ST_IDLE)
    else $error("pause did not advance pointer");

  AST_SPARE_RW: assert property (s_spare_wr_rd |=> o_rdata == $past(i_wdata, 2))
    else $error("spare entry did not keep written value");

  AST_KEY_OPEN: assert property ((i_wr && i_addr == ESQ_KEY_OFS && i_wdata == 8'hF9) |=>
    o_ref_open && key_q == 8'hF9)
    else $error("unlock key did not open references");

  AST_KEY_SHUT: assert property (key_q != 8'hF9 |-> !o_ref_open)
    else $error("references open without unlock key");

  AST_LEVEL_SET: assert property ((i_wr && i_addr == ESQ_CALREF0_OFS && o_ref_open) |=>
    o_cal_level[1:0] == $past(i_wdata[2:1]) && o_man_en[0] == $past(i_wdata[0]))
    else $error("loop zero reference fields not taken");

  AST_LOCKED_WR: assert property ((i_wr && i_addr == ESQ_CALREF0_OFS && !o_ref_open) |=>
    o_cal_level[1:0] == $past(o_cal_level[1:0]) && o_man_en[0] == $past(o_man_en[0]))
    else $error("locked reference write changed contents");

  AST_DATA_CNT: assert property ((state_q == ST_OP && push_go && rb_data <= 8'h7F) |=>
    ret_q == ST_AHI && cnt_q == $past(rb_data[6:0]))
    else $error("data entry count not captured");

endmodule

/* File: verif/esq_ee_model.sv */
// eeprom sink model that records every stored byte with its address
`timescale 1ns/10ps
module esq_ee_model (
  input wire logic i_clock,
  input wire logic i_valid,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_stall,
  input wire logic i_slow,
  output logic o_ready
);
  logic [23:0] log_q[$];
  logic tog;

  initial begin
    o_ready = 1'b0;
    tog = 1'b0;
  end

  // ************************************************************
  // accept bytes; stall or take every other cycle on request
  // ************************************************************
  always @(posedge i_clock) begin
    if (i_valid && o_ready) begin
      log_q.push_back({i_addr, i_data});
    end
    tog <= !tog;
    o_ready <= !i_stall && (!i_slow || tog);
  end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the storage sequence controller
`timescale 1ns/10ps
module tb_top import esq_pkg::*; ;
  logic i_clock, i_nrst, i_wr, i_rd, ee_ready, stall, slow;
  logic [15:0] i_addr;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic o_ee_valid, o_busy, o_ref_open;
  logic [15:0] o_ee_addr;
  logic [7:0] o_ee_data;
  logic [7:0] o_cal_level;
  logic [3:0] o_man_en;
  logic [7:0] exp_q[$];
  int error_cnt, total_checks, cyc, i;

  esq_store_ctl esq_store_ctl_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ee_valid(o_ee_valid),
    .o_ee_addr(o_ee_addr), .o_ee_data(o_ee_data), .i_ee_ready(ee_ready),
    .o_busy(o_busy), .o_ref_open(o_ref_open), .o_cal_level(o_cal_level),
    .o_man_en(o_man_en)
  );

  esq_ee_model esq_ee_model_i (
    .i_clock(i_clock), .i_valid(o_ee_valid), .i_addr(o_ee_addr),
    .i_data(o_ee_data), .i_stall(stall), .i_slow(slow), .o_ready(ee_ready)
  );

  always #10 i_clock = ~i_clock;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask

  // write then read back with no gap between the strobes
  task automatic wrrd(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, d);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // start a store with the sink stalled, then drain and compare all bytes
  task automatic run(input logic [15:0] base);
    int n;
    int k;
    logic [31:0] c;
    n = exp_q.size();
    c = ESQ_CRC_INIT;
    foreach (exp_q[j]) begin
      c = c ^ exp_q[j];
      for (k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ ESQ_CRC_POLY : c >> 1;
    end
    c = ~c;
    for (k = 0; k < 4; k++) exp_q.push_back(c[8*k +: 8]);
    esq_ee_model_i.log_q.delete();
    stall <= 1'b1;
    wr(ESQ_CTRL_OFS, 8'h01);
    repeat (20) @(posedge i_clock);
    #1;
    chk(esq_ee_model_i.log_q.size(), 0);
    chk(o_busy, 1'b1);
    stall <= 1'b0;
    k = 0;
    while ((o_busy !== 1'b0 || o_ee_valid !== 1'b0) && k < 600) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    chk(k < 600, 1'b1);
    @(posedge i_clock);
    #1;
    chk(esq_ee_model_i.log_q.size(), n + 4);
    foreach (exp_q[j]) chk(esq_ee_model_i.log_q[j], {base + 16'(j), exp_q[j]});
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    i_clock = 1'b0;
    i_nrst = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    rdc(ESQ_UPD_OFS, 8'h80);
    rdc(ESQ_CAL_OFS, 8'h92);
    rdc(ESQ_SYNC_OFS, 8'hA0);
    rdc(ESQ_TERM_OFS, 8'hFF);
    rdc(ESQ_SPARE_OFS, 8'h00);
    rdc(ESQ_KEY_OFS, 8'h00);
    rdc(ESQ_CALREF0_OFS, 8'h00);
    chk(o_man_en, 4'h0);
    rdc(16'h0E70, 8'h00);
    $display("test reset done");
    wr(ESQ_CALREF0_OFS, 8'h07);
    rdc(ESQ_CALREF0_OFS, 8'h00);
    wr(ESQ_KEY_OFS, 8'hF8);
    chk(o_ref_open, 1'b0);
    wr(ESQ_CALREF0_OFS, 8'h07);
    rdc(ESQ_CALREF0_OFS, 8'h00);
    $display("test lock done");
    wr(ESQ_KEY_OFS, ESQ_KEY_OPEN);
    chk(o_ref_open, 1'b1);
    rdc(ESQ_KEY_OFS, 8'hF9);
    for (i = 0; i < ESQ_LOOPS; i++) begin
      wr(16'(ESQ_CALREF0_OFS + ESQ_CALREF_STEP * i), 8'(8'hF8 | (i << 1) | (i & 1)));
      rdc(16'(ESQ_CALREF0_OFS + ESQ_CALREF_STEP * i), 8'((i << 1) | (i & 1)));
    end
    chk(o_cal_level, 8'hE4);
    chk(o_man_en, 4'hA);
    wr(16'h000F, 8'h01);
    wr(ESQ_KEY_OFS, 8'h00);
    chk(o_ref_open, 1'b0);
    wr(ESQ_CALREF0_OFS, 8'h03);
    chk(o_man_en, 4'hA);
    $display("test unlock done");
    exp_q = {8'h80, 8'h92, 8'hA0, 8'hFF};
    run(16'h0000);
    rdc(ESQ_PTRL_OFS, 8'h00);
    rdc(ESQ_STAT_OFS, 8'h00);
    $display("test default store done");
    wr(ESQ_TERM_OFS, 8'h01);
    wrrd(ESQ_SPARE_OFS, 8'h0E);
    wr(16'h0E63, 8'h5F);
    wr(16'h0E64, ESQ_OP_PAUSE);
    rdc(16'h0E63, 8'h5F);
    rdc(16'h0E64, 8'hFE);
    slow <= 1'b1;
    exp_q = {8'h80, 8'h92, 8'hA0, 8'h01, 8'h0E, 8'h5F, 8'h92, 8'hA0, 8'hFE};
    run(16'h0000);
    rdc(ESQ_PTRL_OFS, 8'h0D);
    exp_q = {8'h80, 8'h92, 8'hA0, 8'h01, 8'h0E, 8'h5F, 8'h92, 8'hA0, 8'hFE};
    run(16'h000D);
    rdc(ESQ_PTRL_OFS, 8'h1A);
    rdc(ESQ_PTRH_OFS, 8'h00);
    $display("test pause store done");
    wr(16'h0E64, ESQ_OP_CAL);
    wr(ESQ_CTRL_OFS, 8'h01);
    repeat (200) @(posedge i_clock);
    #1;
    rdc(ESQ_STAT_OFS, 8'h02);
    rdc(ESQ_PTRL_OFS, 8'h31);
    $display("test missing terminator done");
    summarize();
  end
endmodule
